// ===== core/dac_bank_update_sequencer.sv
// Update sequencer for two banks of sixteen level-setting converters
//
// Notes on behaviour
// - Thirty-two 16-bit converters, two banks of sixteen, one bank per channel.
// - Each converter except the threshold slots of the bank other than OVD_BANK can be written alone, by slot address and channel selection.
// - Analog update and deglitch start four serial clocks after chip select release.
// - Immediate or deferred update is chosen separately for each bank.
// - Immediate bank: any write starts its update after chip select release.
// - Immediate update also commits codes queued earlier; mode switch keeps them.
// - Load trigger does nothing while its bank is immediate.
// - Deferred bank only queues; its load trigger commits all queued codes together.
// - Overvoltage threshold converters update with their assigned bank and its mode.
// - Dual-channel write hits both banks, threshold slots only their assigned bank; each bank then follows its own mode.
// - Each bank owns an independent deglitch timer of about 3 us.
// - A new update during deglitch restarts that bank's timer.
// - Outputs move after deglitch expiry; settling adds 7 us, 10 us total.
// - Voltage codes map linearly, code zero at the bottom of the range.
// - Force-current codes: mid-scale means zero current, symmetric bipolar range.
// - One result register per converter, applied at update and read back.
`timescale 1ns/1ps
`include "dac_seq_cfg.svh"
module dac_bank_update_sequencer #(
   parameter int DEGLITCH_NS = `DAC_DEGLITCH_NS,
   parameter int SETTLE_NS = `DAC_SETTLE_NS,
   parameter int UPDATE_SCLKS = `DAC_UPDATE_SCLKS,
   parameter int OVD_BANK = 0
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Decoded serial writes
   input wire logic wrValid,
   input wire logic [3:0] wrSlot,
   input wire logic [1:0] wrChan,
   input wire logic [15:0] wrCode,
   input wire logic csRelease,
   input wire logic sclkRise,
   // Bank control bits
   input wire logic [1:0] deferMode,
   input wire logic [1:0] loadTrig,
   // Readback
   input wire logic rdValid,
   input wire logic [3:0] rdSlot,
   input wire logic rdChan,
   output logic [15:0] rdData_q,
   // Converter levels and status
   output logic [511:0] dacLevel_q,
   output logic [31:0] forceCurrent_q,
   output logic [1:0] queued_q,
   output logic [1:0] deglitching_q,
   output logic [1:0] settled_q
);
   // Least times round up to whole mclk cycles
   localparam int DEGLITCH_CYC = (DEGLITCH_NS * 1000 + `DAC_MCLK_PERIOD_PS - 1) / `DAC_MCLK_PERIOD_PS;
   localparam int SETTLE_CYC = (SETTLE_NS * 1000 + `DAC_MCLK_PERIOD_PS - 1) / `DAC_MCLK_PERIOD_PS;

   // Bank counters are 16 bits wide, the serial clock count 4 bits; the bank select is one bit
   generate
      if (DEGLITCH_CYC < 1 || DEGLITCH_CYC > 65535 || SETTLE_CYC < 1 || SETTLE_CYC > 65535) begin : g_bad_time
         $error("Timing counts do not fit the bank counters");
      end
      if (UPDATE_SCLKS < 1 || UPDATE_SCLKS > 15) begin : g_bad_sclk
         $error("Update delay must be 1 to 15 serial clocks");
      end
      if (OVD_BANK < 0 || OVD_BANK > 1) begin : g_bad_ovd
         $error("Overvoltage threshold bank must be 0 or 1");
      end
      // Port widths are fixed at two banks of sixteen 16-bit codes
      if (`DAC_NUM_BANKS != 2 || `DAC_PER_BANK != 16 || `DAC_CODE_W != 16) begin : g_bad_shape
         $error("Port widths assume two banks of sixteen 16-bit converters");
      end
      // Threshold and force slots must name three different converters
      if ((`DAC_OVH_SLOT == `DAC_OVL_SLOT) || (`DAC_FORCE_SLOT == `DAC_OVH_SLOT) ||
         (`DAC_FORCE_SLOT == `DAC_OVL_SLOT)) begin : g_bad_slot
         $error("Special converter slots overlap");
      end
   endgenerate

   // One link per bank, indexed by the bank number
   bank_if bankBus [`DAC_NUM_BANKS] ();

   // Frame tracking and the serial clock delay
   logic isOvd;
   logic [1:0] targetBanks;
   logic [1:0] frameBanks_q, frameBanks_d;
   logic [1:0] waitBanks_q;
   logic [3:0] sclkCnt_q;
   logic counting_q;
   logic fireNow;
   logic [1:0] fireBanks;
   logic [1:0] frameHit;
   logic [1:0] armBanks;
   logic armNow, sclkLast;

   // Threshold slots belong to one bank whichever channel is named
   assign isOvd = (wrSlot == `DAC_OVH_SLOT) || (wrSlot == `DAC_OVL_SLOT);
   // A dual write to a threshold slot still lands only once
   assign targetBanks = isOvd ? ((|wrChan) ? (2'b01 << OVD_BANK) : 2'b00) : wrChan;

   // Banks touched by a write in this very cycle count for the frame too
   assign frameHit = wrValid ? targetBanks : 2'b00;
   // Banks written in the frame now open; a release hands them to the delay
   assign frameBanks_d = csRelease ? 2'b00 : (frameBanks_q | frameHit);
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         frameBanks_q <= 2'b00;
      end else begin
         frameBanks_q <= frameBanks_d;
      end
   end

   // Fire on the fourth serial clock edge after release; the host must keep
   // the serial clock running long enough for this count to complete
   // Banks armed by a release that never sees enough serial clocks stay armed
   assign sclkLast = (sclkCnt_q == 4'(UPDATE_SCLKS - 1));
   assign fireNow = counting_q && sclkRise && sclkLast;
   assign fireBanks = fireNow ? waitBanks_q : 2'b00;
   // A release with no converter write in its frame arms nothing
   assign armBanks = frameBanks_q | frameHit;
   assign armNow = csRelease && (|armBanks);

   // A second release while waiting merges banks and restarts the count
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         waitBanks_q <= 2'b00;
         sclkCnt_q <= 4'h0;
         counting_q <= 1'b0;
      end else if (armNow) begin
         waitBanks_q <= (fireNow ? 2'b00 : waitBanks_q) | armBanks;
         sclkCnt_q <= 4'h0;
         counting_q <= 1'b1;
      end else if (fireNow) begin
         waitBanks_q <= 2'b00;
         sclkCnt_q <= 4'h0;
         counting_q <= 1'b0;
      end else if (counting_q && sclkRise) begin
         sclkCnt_q <= sclkCnt_q + 4'h1;
      end
   end

   // One bank instance per channel, each with its own mode and timer
   genvar b;
   generate
      for (b = 0; b < `DAC_NUM_BANKS; b++) begin : g_bank
         assign bankBus[b].wrEn = wrValid && targetBanks[b];
         assign bankBus[b].wrSlot = wrSlot;
         assign bankBus[b].wrCode = wrCode;
         assign bankBus[b].fire = fireBanks[b];
         assign bankBus[b].load = loadTrig[b];
         assign bankBus[b].defer = deferMode[b];
         dac_bank #(
            .DEGLITCH_CYC(DEGLITCH_CYC),
            .SETTLE_CYC(SETTLE_CYC)
         ) u_bank (
            .mclk(mclk),
            .nrst(nrst),
            .bus(bankBus[b])
         );
      end
   endgenerate

   // Taps on the two bank links
   dac_seq_pkg::bank_codes_t res0, res1, lvl0, lvl1;
   logic [15:0] pend0, pend1;
   logic [1:0] dgNow, stNow;
   dac_seq_pkg::code_t rdSel;
   dac_seq_pkg::code_t force0, force1;

   assign res0 = bankBus[0].result;
   assign res1 = bankBus[1].result;
   assign lvl0 = bankBus[0].level;
   assign lvl1 = bankBus[1].level;
   assign pend0 = bankBus[0].pending;
   assign pend1 = bankBus[1].pending;
   assign dgNow = {bankBus[1].deglitching, bankBus[0].deglitching};
   assign stNow = {bankBus[1].settled, bankBus[0].settled};
   assign rdSel = rdChan ? res1[rdSlot] : res0[rdSlot];
   // Mid-scale is zero current: flipping the top bit gives a signed current
   assign force0 = lvl0[`DAC_FORCE_SLOT] ^ `DAC_MIDSCALE;
   assign force1 = lvl1[`DAC_FORCE_SLOT] ^ `DAC_MIDSCALE;

   // Readback returns the result register, not the applied level
   // A read in the cycle of a write to that slot returns the older code
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         rdData_q <= 16'h0000;
      end else if (rdValid) begin
         rdData_q <= rdSel;
      end
   end

   // Output copies keep every port on a flip-flop; levels lag by one cycle
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         dacLevel_q <= '0;
      end else begin
         dacLevel_q <= {lvl1, lvl0};
      end
   end

   // Signed force-current view follows the applied force slot codes
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         forceCurrent_q <= 32'h0000_0000;
      end else begin
         forceCurrent_q <= {force1, force0};
      end
   end

   // Bank status; settled reads high out of reset since nothing is pending
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         queued_q <= 2'b00;
         deglitching_q <= 2'b00;
         settled_q <= 2'b11;
      end else begin
         queued_q <= {|pend1, |pend0};
         deglitching_q <= dgNow;
         settled_q <= stNow;
      end
   end
endmodule // dac_bank_update_sequencer

// ===== core/dac_seq_cfg.svh
// Constants for the converter bank update sequencer
`ifndef DAC_SEQ_CFG_SVH
`define DAC_SEQ_CFG_SVH
`define DAC_NUM_BANKS 2
`define DAC_PER_BANK 16
`define DAC_CODE_W 16
`define DAC_MCLK_PERIOD_PS 5000
`define DAC_DEGLITCH_NS 3000
`define DAC_SETTLE_NS 7000
`define DAC_UPDATE_SCLKS 4
`define DAC_OVH_SLOT 4'hE
`define DAC_OVL_SLOT 4'hF
`define DAC_FORCE_SLOT 4'hD
`define DAC_MIDSCALE 16'h8000
`define DAC_CODE_RESET 16'h0000
`endif

// ===== core/dac_seq_pkg.sv
// Types shared by the sequencer modules
package dac_seq_pkg;
   typedef logic [15:0] code_t;
   typedef logic [3:0] slot_t;
   typedef logic [15:0][15:0] bank_codes_t;
   typedef enum logic [1:0] {PH_IDLE, PH_DEGLITCH, PH_SETTLE} phase_t;
endpackage

// ===== core/bank_if.sv
// Link between the sequencer front end and one converter bank
`timescale 1ns/1ps
interface bank_if;
   logic wrEn;
   dac_seq_pkg::slot_t wrSlot;
   dac_seq_pkg::code_t wrCode;
   logic fire;
   logic load;
   logic defer;
   dac_seq_pkg::bank_codes_t result;
   dac_seq_pkg::bank_codes_t level;
   logic [15:0] pending;
   logic deglitching;
   logic settled;
   modport seq (output wrEn, wrSlot, wrCode, fire, load, defer,
      input result, level, pending, deglitching, settled);
   modport bank (input wrEn, wrSlot, wrCode, fire, load, defer,
      output result, level, pending, deglitching, settled);
endinterface

// ===== core/dac_bank.sv
// One bank of sixteen converters: queue, commit, deglitch and settle timing
`timescale 1ns/1ps
`include "dac_seq_cfg.svh"
module dac_bank #(
   parameter int DEGLITCH_CYC = 600,
   parameter int SETTLE_CYC = 1400
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Front end link
   bank_if.bank bus
);
   dac_seq_pkg::bank_codes_t result_q, stage_q, level_q;
   logic [15:0] pend_q, commit_q, pend_d;
   logic [15:0] cnt_q;
   dac_seq_pkg::phase_t phase_q;
   logic settled_q;
   logic startNow, expire, settleDone;
   logic [15:0] wrMask;

   // Immediate banks start on fire; deferred banks only on their load trigger
   assign startNow = (bus.fire & ~bus.defer) | (bus.load & bus.defer);
   assign expire = (phase_q == dac_seq_pkg::PH_DEGLITCH) && (cnt_q == 16'h0000);
   assign settleDone = (phase_q == dac_seq_pkg::PH_SETTLE) && (cnt_q == 16'h0000);
   assign wrMask = bus.wrEn ? (16'h0001 << bus.wrSlot) : 16'h0000;
   // A write landing with a start stays queued: the set wins over the clear
   assign pend_d = (startNow ? 16'h0000 : pend_q) | wrMask;

   // Result registers, queue marks and commit staging
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         pend_q <= 16'h0000;
         commit_q <= 16'h0000;
         for (int i = 0; i < 16; i++) begin
            result_q[i] <= `DAC_CODE_RESET;
            stage_q[i] <= `DAC_CODE_RESET;
            level_q[i] <= `DAC_CODE_RESET;
         end
      end else begin
         pend_q <= pend_d;
         if (bus.wrEn) begin
            result_q[bus.wrSlot] <= bus.wrCode;
         end
         for (int i = 0; i < 16; i++) begin
            // Every queued code goes along, not only the one just written
            if (startNow && pend_q[i]) begin
               stage_q[i] <= result_q[i];
            end
            // Outputs move only once the deglitch window closes
            if (expire && !startNow && commit_q[i]) begin
               level_q[i] <= stage_q[i];
            end
         end
         if (startNow) begin
            commit_q <= commit_q | pend_q;
         end else if (expire) begin
            commit_q <= 16'h0000;
         end
      end
   end

   // mclk timer that counts only outside idle; a restart during deglitch extends it
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         phase_q <= dac_seq_pkg::PH_IDLE;
         cnt_q <= 16'h0000;
         settled_q <= 1'b1;
      end else if (startNow) begin
         phase_q <= dac_seq_pkg::PH_DEGLITCH;
         cnt_q <= 16'(DEGLITCH_CYC - 1);
         settled_q <= 1'b0;
      end else if (expire) begin
         phase_q <= dac_seq_pkg::PH_SETTLE;
         cnt_q <= 16'(SETTLE_CYC - 1);
      end else if (settleDone) begin
         phase_q <= dac_seq_pkg::PH_IDLE;
         settled_q <= 1'b1;
      end else if (phase_q != dac_seq_pkg::PH_IDLE) begin
         cnt_q <= cnt_q - 16'h0001;
      end
   end

   assign bus.result = result_q;
   assign bus.level = level_q;
   assign bus.pending = pend_q;
   assign bus.deglitching = (phase_q == dac_seq_pkg::PH_DEGLITCH);
   assign bus.settled = settled_q;
endmodule // dac_bank

// ===== tb/dac_seq_monitor.sv
// Port-level checks for the converter bank update sequencer
`timescale 1ns/1ps
module dac_seq_monitor (
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Requests
   input wire logic wrValid,
   input wire logic [3:0] wrSlot,
   input wire logic [1:0] wrChan,
   input wire logic [1:0] deferMode,
   input wire logic [1:0] loadTrig,
   input wire logic sclkRise,
   // Outputs watched
   input wire logic [511:0] dacLevel_q,
   input wire logic [31:0] forceCurrent_q,
   input wire logic [1:0] queued_q,
   input wire logic [1:0] deglitching_q,
   input wire logic [1:0] settled_q
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   // Reset state, outputs held during deglitch, start timing, queueing and force mapping
   a_reset_state:
      assert property ($rose(nrst) |-> settled_q == 2'b11 && queued_q == 2'b00 && deglitching_q == 2'b00)
      else $error("state not cleared by reset");
   a_hold_bank0:
      assert property (deglitching_q[0] |-> $stable(dacLevel_q[255:0])) else $error("bank0 moved in deglitch");
   a_hold_bank1:
      assert property (deglitching_q[1] |-> $stable(dacLevel_q[511:256])) else $error("bank1 moved in deglitch");
   a_move_after_dg:
      assert property ($changed(dacLevel_q[255:0]) |-> $past(deglitching_q[0])) else $error("bank0 moved early");
   a_dg_not_settled:
      assert property ((deglitching_q & settled_q) == 2'b00) else $error("settled while deglitching");
   a_settle_gap:
      assert property ($fell(deglitching_q[1]) |-> (!settled_q[1]) [*4]) else $error("settle phase skipped");
   a_load_start:
      assert property (deferMode[1] && loadTrig[1] |-> ##2 deglitching_q[1]) else $error("load did not start");
   a_queue_set:
      assert property (wrValid && wrChan[1] && wrSlot < 4'hE ##1 !loadTrig[1] |-> ##1 queued_q[1])
      else $error("write not queued");
   a_force_map:
      assert property ($changed(forceCurrent_q[15:0]) |-> forceCurrent_q[15:0] == (dacLevel_q[223:208] ^ 16'h8000))
      else $error("force code not offset");
   a_fire_on_sclk:
      assert property ($rose(deglitching_q[0]) |->
         $past(sclkRise, 2) || ($past(loadTrig[0], 2) && $past(deferMode[0], 2)))
      else $error("bank0 started off a serial clock edge");

   // Main scenarios reached
   c_dual_write: cover property (wrValid && wrChan == 2'b11);
   c_load: cover property (deferMode[1] && loadTrig[1]);
   c_retrigger: cover property (deglitching_q[1] && loadTrig[1]);
endmodule // dac_seq_monitor

bind dac_bank_update_sequencer dac_seq_monitor mon_u (.mclk(mclk), .nrst(nrst), .wrValid(wrValid),
   .wrSlot(wrSlot), .wrChan(wrChan), .deferMode(deferMode), .loadTrig(loadTrig), .sclkRise(sclkRise),
   .dacLevel_q(dacLevel_q), .forceCurrent_q(forceCurrent_q), .queued_q(queued_q), .deglitching_q(deglitching_q),
   .settled_q(settled_q));

// ===== tb/spi_host_model.sv
// Serial host model: decoded write, chip select release, trailing serial clocks
`timescale 1ns/1ps
module spi_host_model #(
   parameter int SCLK_GAP = 2
) (
   // Clock
   input wire logic mclk,
   // Frame events
   output logic wrValid,
   output logic [3:0] wrSlot,
   output logic [1:0] wrChan,
   output logic [15:0] wrCode,
   output logic csRelease,
   output logic sclkRise
);
   // Serial clock stands still between frames
   initial begin
      wrValid = 0;
      wrSlot = 4'h0;
      wrChan = 2'h0;
      wrCode = 16'h0000;
      csRelease = 0;
      sclkRise = 0;
   end

   // Released data lines show the inverse so stale values are never trusted
   task automatic frame(input logic [3:0] s, input logic [1:0] c, input logic [15:0] d);
      int n;
      n = (s == 4'h1 || s == 4'h3) ? 21 : 18;
      @(posedge mclk) #1;
      wrValid = 1;
      wrSlot = s;
      wrChan = c;
      wrCode = d;
      @(posedge mclk) #1;
      wrValid = 0;
      wrCode = ~d;
      csRelease = 1;
      @(posedge mclk) #1;
      csRelease = 0;
      repeat (n) begin
         sclkRise = 1;
         @(posedge mclk) #1;
         sclkRise = 0;
         repeat (SCLK_GAP - 1) @(posedge mclk);
         #1;
      end
   endtask
endmodule // spi_host_model

// ===== tb/tb.sv
// Self-checking bench for the converter bank update sequencer
`timescale 1ns/1ps
`define CHK(nm, e, s) begin cmpCount++; if ((s) !== (e)) begin miscompares++; \
   $display("mismatch %s exp %h got %h", nm, e, s); end end
module tb;
   logic mclk, nrst, wrValid, csRelease, sclkRise, rdValid, rdChan;
   logic [3:0] wrSlot, rdSlot;
   logic [1:0] wrChan, deferMode, loadTrig, queued, dglitch, settled;
   logic [15:0] wrCode, rdData;
   logic [511:0] dacLevel;
   logic [31:0] forceCurrent;
   int miscompares = 0;
   int cmpCount = 0;

   // Short timers keep the run brief
   dac_bank_update_sequencer #(.DEGLITCH_NS(40), .SETTLE_NS(30)) dut_u (.mclk(mclk), .nrst(nrst),
      .wrValid(wrValid), .wrSlot(wrSlot), .wrChan(wrChan), .wrCode(wrCode), .csRelease(csRelease),
      .sclkRise(sclkRise), .deferMode(deferMode), .loadTrig(loadTrig), .rdValid(rdValid), .rdSlot(rdSlot),
      .rdChan(rdChan), .rdData_q(rdData), .dacLevel_q(dacLevel), .forceCurrent_q(forceCurrent),
      .queued_q(queued), .deglitching_q(dglitch), .settled_q(settled));
   spi_host_model host_u (.mclk(mclk), .wrValid(wrValid), .wrSlot(wrSlot), .wrChan(wrChan),
      .wrCode(wrCode), .csRelease(csRelease), .sclkRise(sclkRise));

   // 200 MHz clock
   initial begin
      mclk = 0;
      forever #2.5 mclk = ~mclk;
   end

   function automatic logic [15:0] lvl(input int b, input int s);
      return dacLevel[(b * 16 + s) * 16 +: 16];
   endfunction

   task automatic rd(input logic [3:0] s, input logic c, input logic [15:0] e);
      @(posedge mclk) #1;
      rdValid = 1;
      rdSlot = s;
      rdChan = c;
      @(posedge mclk) #1;
      rdValid = 0;
      `CHK("rdData", e, rdData)
   endtask

   task automatic ld(input logic [1:0] m);
      @(posedge mclk) #1;
      loadTrig = m;
      @(posedge mclk) #1;
      loadTrig = 2'b00;
   endtask

   // Bounded wait until both banks are idle again
   task automatic settle();
      int n;
      n = 0;
      repeat (4) @(posedge mclk);
      while (settled !== 2'b11 && n < 300) begin
         @(posedge mclk);
         n++;
      end
      if (n >= 300) begin
         miscompares++;
         $display("mismatch settled exp 3 got %h", settled);
      end
      #1;
   endtask

   task automatic testDone();
      $display("compares %0d mismatches %0d", cmpCount, miscompares);
      if (miscompares == 0 && cmpCount > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Watchdog well beyond the expected few hundred cycles
   initial begin
      #50000;
      miscompares++;
      $display("mismatch watchdog exp done got hang");
      testDone();
   end

   // Test sequence
   initial begin
      nrst = 0;
      deferMode = 2'b00;
      loadTrig = 2'b00;
      rdValid = 0;
      rdSlot = 4'h0;
      rdChan = 0;
      repeat (4) @(posedge mclk);
      #1 nrst = 1;
      `CHK("levels", 512'h0, dacLevel)
      deferMode = 2'b10;
      // The fourth trailing serial clock lands on the tenth edge of the frame
      fork
         host_u.frame(4'h2, 2'b11, 16'h1234);
         begin
            repeat (9) @(posedge mclk);
            #1;
            `CHK("dg before fire", 2'b00, dglitch)
            repeat (2) @(posedge mclk);
            #1;
            `CHK("dg after fire", 2'b01, dglitch)
         end
      join
      settle();
      `CHK("b0 s2", 16'h1234, lvl(0, 2))
      `CHK("b1 s2", 16'h0000, lvl(1, 2))
      `CHK("queued", 2'b10, queued)
      rd(4'h2, 1'b1, 16'h1234);
      ld(2'b01);
      @(posedge mclk) #1;
      `CHK("dg imm load", 2'b00, dglitch)
      ld(2'b10);
      settle();
      `CHK("b1 s2 load", 16'h1234, lvl(1, 2))
      `CHK("queued", 2'b00, queued)
      // Queue on bank 0 while deferred, then return it to immediate
      deferMode = 2'b11;
      host_u.frame(4'h5, 2'b01, 16'hA5A5);
      `CHK("b0 s5 held", 16'h0000, lvl(0, 5))
      deferMode = 2'b10;
      host_u.frame(4'h6, 2'b01, 16'h5A5A);
      settle();
      `CHK("b0 s5", 16'hA5A5, lvl(0, 5))
      `CHK("b0 s6", 16'h5A5A, lvl(0, 6))
      host_u.frame(4'hE, 2'b10, 16'hBEEF);
      host_u.frame(4'hD, 2'b01, 16'h8000);
      settle();
      `CHK("b0 s14", 16'hBEEF, lvl(0, 14))
      `CHK("b1 s14", 16'h0000, lvl(1, 14))
      `CHK("force zero", 16'h0000, forceCurrent[15:0])
      // Second load two cycles into an eight cycle deglitch
      host_u.frame(4'h3, 2'b10, 16'h0F0F);
      ld(2'b10);
      ld(2'b10);
      repeat (8) @(posedge mclk);
      #1;
      `CHK("dg stretched", 2'b10, dglitch)
      `CHK("b1 s3 early", 16'h0000, lvl(1, 3))
      settle();
      `CHK("b1 s3", 16'h0F0F, lvl(1, 3))
      testDone();
   end
endmodule // tb
